// ### shared/bcx_pkg.sv
package bcx_pkg;
  // Widths
  localparam int PC_W       = 21;
  localparam int ADDR_W     = 12;
  localparam int MEM_DEPTH  = 4096;
  // Opcode fields
  localparam logic [7:0] OP_BR_CARRY = 8'he2;
  localparam logic [7:0] OP_BR_NEG   = 8'he6;
  localparam logic [3:0] OP_BIT_CLR  = 4'h9;
  // Field positions
  localparam int HI_BYTE_MSB   = 15;
  localparam int HI_BYTE_LSB   = 8;
  localparam int CLR_OP_LSB    = 12;
  localparam int BIT_SEL_MSB   = 11;
  localparam int BIT_SEL_LSB   = 9;
  localparam int BANK_MODE_BIT = 8;
  // Addressing constants
  localparam logic [PC_W-1:0] INSTR_BYTES   = 21'h000002;
  localparam logic [7:0]      ILO_LIMIT     = 8'h5f;
  localparam logic [7:0]      ACCESS_SPLIT  = 8'h60;
  localparam logic [3:0]      ACCESS_HI_BNK = 4'hf;
  localparam logic [3:0]      ACCESS_LO_BNK = 4'h0;
  // Quarter cycle codes
  localparam logic [1:0] Q1 = 2'h0;
  localparam logic [1:0] Q2 = 2'h1;
  localparam logic [1:0] Q3 = 2'h2;
  localparam logic [1:0] Q4 = 2'h3;
  // Reset values
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_FLUSH} bcx_state_type;
  typedef enum logic [1:0] {K_NONE, K_BR_CARRY, K_BR_NEG, K_CLR} bcx_kind_type;

  // Sign extended offset, doubled
  function automatic logic [PC_W-1:0] offset_x2(input logic [7:0] n);
    offset_x2 = {{(PC_W-9){n[7]}}, n, 1'b0};
  endfunction

  // Branch target from instruction address
  function automatic logic [PC_W-1:0] branch_target(input logic [PC_W-1:0] pc,
                                                    input logic [7:0]      n);
    branch_target = pc + INSTR_BYTES + offset_x2(n);
  endfunction

  // Data memory address for a file operand
  function automatic logic [ADDR_W-1:0] file_addr(input logic             a,
                                                  input logic             ext,
                                                  input logic [7:0]       f,
                                                  input logic [3:0]       bank_ptr,
                                                  input logic [ADDR_W-1:0] base);
    if (a)
      file_addr = {bank_ptr, f};
    else if (ext && (f <= ILO_LIMIT))
      file_addr = base + {4'h0, f};
    else if (f < ACCESS_SPLIT)
      file_addr = {ACCESS_LO_BNK, f};
    else
      file_addr = {ACCESS_HI_BNK, f};
  endfunction

  // One-hot bit mask
  function automatic logic [7:0] bit_mask(input logic [2:0] b);
    bit_mask = 8'h01 << b;
  endfunction
endpackage

// ### shared/bcx_mem_if.sv
`timescale 1ns/10ps
interface bcx_mem_if;
  logic                       ce;
  logic                       rd_en;
  logic                       we;
  logic [bcx_pkg::ADDR_W-1:0] addr;
  logic [7:0]                 wdata;
  logic [7:0]                 rdata;
  modport core (output ce, rd_en, we, addr, wdata, input rdata);
  modport mem  (input ce, rd_en, we, addr, wdata, output rdata);
endinterface

// ### hw/bcx_dmem.sv
`timescale 1ns/10ps
module bcx_dmem (
  input  wire logic   clk_i,   // Core clock
  input  wire logic   reset_i, // Async reset, high
  bcx_mem_if.mem      mem      // Access port
);
  logic [7:0] store [bcx_pkg::MEM_DEPTH];
  logic [7:0] rdata_r;

  // Array write
  always_ff @(posedge clk_i) begin
    if (mem.ce && mem.we) begin
      store[mem.addr] <= mem.wdata;
    end
  end

  // Registered read
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_r <= 8'h00;
    end else if (mem.ce && mem.rd_en) begin
      rdata_r <= store[mem.addr];
    end
  end

  assign mem.rdata = rdata_r;
endmodule // bcx_dmem

// ### hw/bcx_exec.sv
`timescale 1ns/10ps
module bcx_exec (
  input  wire logic        CLK_I,          // Core clock
  input  wire logic        RESET_I,        // Async reset, high
  input  wire logic        CE_I,           // Clock enable
  input  wire logic        INSTR_VALID_I,  // Instruction offered
  input  wire logic [15:0] INSTR_I,        // Instruction word
  input  wire logic [20:0] INSTR_PC_I,     // Address of the instruction
  input  wire logic        CARRY_I,        // Carry flag
  input  wire logic        NEGATIVE_I,     // Negative flag
  input  wire logic        EXT_SET_EN_I,   // Extended set enabled
  input  wire logic [3:0]  BANK_SEL_I,     // Bank select pointer
  input  wire logic [11:0] INDEX_BASE_I,   // Base for indexed literal offset
  input  wire logic [11:0] DBG_ADDR_I,     // Idle-time memory address
  input  wire logic        DBG_WE_I,       // Idle-time memory write
  input  wire logic [7:0]  DBG_WDATA_I,    // Idle-time write data
  output logic             INSTR_READY_O,  // Ready to take instruction
  output logic [1:0]       QPHASE_O,       // Current quarter
  output logic             PC_WE_O,        // Program counter write
  output logic [20:0]      PC_O,           // Next program counter
  output logic             DONE_O,         // Instruction finished
  output logic             STATUS_WE_O,    // Status flag write
  output logic [7:0]       DBG_RDATA_O     // Memory read data
);
  bcx_mem_if mif ();

  bcx_pkg::bcx_state_type state_r;
  bcx_pkg::bcx_kind_type  kind_r;
  logic [1:0]             q_r;
  logic [15:0]            instr_r;
  logic [20:0]            pc_r;
  logic [20:0]            pc_out_r;
  logic                   carry_r;
  logic                   neg_r;
  logic                   ext_r;
  logic [3:0]             bank_ptr_r;
  logic [11:0]            base_r;
  logic                   taken_r;
  logic [7:0]             off_r;
  logic [11:0]            addr_r;
  logic [7:0]             mod_r;
  logic                   accept;
  logic                   last_q;
  logic                   exec_q;

  bcx_dmem bcx_dmem_i (
    .clk_i   (CLK_I),
    .reset_i (RESET_I),
    .mem     (mif.mem)
  );

  // Handshake and phase decode
  assign accept        = (state_r == bcx_pkg::ST_IDLE) && INSTR_VALID_I;
  assign last_q        = (q_r == bcx_pkg::Q4);
  assign exec_q        = (state_r == bcx_pkg::ST_EXEC);
  assign INSTR_READY_O = (state_r == bcx_pkg::ST_IDLE);
  assign QPHASE_O      = q_r;
  assign PC_O          = pc_out_r;
  assign DBG_RDATA_O   = mif.rdata;
  assign STATUS_WE_O   = 1'b0;

  // Sequencer: one or two instruction cycles of four quarters
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      state_r <= bcx_pkg::ST_IDLE;
      q_r     <= bcx_pkg::Q1;
    end else if (CE_I) begin
      case (state_r)
        bcx_pkg::ST_IDLE: begin
          q_r <= bcx_pkg::Q1;
          if (INSTR_VALID_I) begin
            state_r <= bcx_pkg::ST_EXEC;
          end
        end
        bcx_pkg::ST_EXEC: begin
          q_r <= q_r + 2'h1;
          if (last_q) begin
            state_r <= taken_r ? bcx_pkg::ST_FLUSH : bcx_pkg::ST_IDLE;
          end
        end
        bcx_pkg::ST_FLUSH: begin
          q_r <= q_r + 2'h1;
          if (last_q) begin
            state_r <= bcx_pkg::ST_IDLE;
          end
        end
        default: begin
          state_r <= bcx_pkg::ST_IDLE;
          q_r     <= bcx_pkg::Q1;
        end
      endcase
    end
  end

  // Capture of instruction and context on acceptance
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      instr_r <= 16'h0000;
      pc_r    <= bcx_pkg::PC_RESET;
      carry_r <= 1'b0;
      neg_r   <= 1'b0;
      ext_r   <= 1'b0;
      bank_ptr_r <= 4'h0;
      base_r  <= 12'h000;
    end else if (CE_I && accept) begin
      instr_r <= INSTR_I;
      pc_r    <= INSTR_PC_I;
      carry_r <= CARRY_I;
      neg_r   <= NEGATIVE_I;
      ext_r   <= EXT_SET_EN_I;
      bank_ptr_r <= BANK_SEL_I;
      base_r  <= INDEX_BASE_I;
    end
  end

  // Q1 decode, condition test and operand address
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      kind_r  <= bcx_pkg::K_NONE;
      taken_r <= 1'b0;
      addr_r  <= 12'h000;
    end else if (CE_I && exec_q && (q_r == bcx_pkg::Q1)) begin
      addr_r  <= bcx_pkg::file_addr(instr_r[bcx_pkg::BANK_MODE_BIT], ext_r,
                                    instr_r[7:0], bank_ptr_r, base_r);
      taken_r <= 1'b0;
      kind_r  <= bcx_pkg::K_NONE;
      if (instr_r[bcx_pkg::HI_BYTE_MSB:bcx_pkg::HI_BYTE_LSB] == bcx_pkg::OP_BR_CARRY) begin
        kind_r  <= bcx_pkg::K_BR_CARRY;
        taken_r <= carry_r;
      end else if (instr_r[bcx_pkg::HI_BYTE_MSB:bcx_pkg::HI_BYTE_LSB]
                   == bcx_pkg::OP_BR_NEG) begin
        kind_r  <= bcx_pkg::K_BR_NEG;
        taken_r <= neg_r;
      end else if (instr_r[15:bcx_pkg::CLR_OP_LSB] == bcx_pkg::OP_BIT_CLR) begin
        kind_r <= bcx_pkg::K_CLR;
      end
    end
  end

  // Q2 literal read, Q3 data processing
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      off_r    <= 8'h00;
      mod_r    <= 8'h00;
      pc_out_r <= bcx_pkg::PC_RESET;
    end else if (CE_I && exec_q) begin
      if (q_r == bcx_pkg::Q2) begin
        off_r <= instr_r[7:0];
      end
      if (q_r == bcx_pkg::Q3) begin
        pc_out_r <= taken_r ? bcx_pkg::branch_target(pc_r, off_r)
                            : pc_r + bcx_pkg::INSTR_BYTES;
        mod_r    <= mif.rdata & ~bcx_pkg::bit_mask(
                    instr_r[bcx_pkg::BIT_SEL_MSB:bcx_pkg::BIT_SEL_LSB]);
      end
    end
  end

  // Q4 program counter write and completion
  assign PC_WE_O = CE_I && exec_q && last_q && taken_r;
  assign DONE_O  = CE_I && last_q &&
                   ((exec_q && !taken_r) || (state_r == bcx_pkg::ST_FLUSH));

  // Memory port: Q2 read, Q4 write back, debug access while idle
  always_comb begin
    mif.ce    = CE_I;
    mif.rd_en = 1'b1;
    mif.we    = 1'b0;
    mif.addr  = DBG_ADDR_I;
    mif.wdata = DBG_WDATA_I;
    if (state_r == bcx_pkg::ST_IDLE) begin
      mif.we = DBG_WE_I;
    end else begin
      mif.rd_en = exec_q && (q_r == bcx_pkg::Q2);
      mif.addr  = addr_r;
      mif.wdata = mod_r;
      mif.we    = exec_q && last_q && (kind_r == bcx_pkg::K_CLR);
    end
  end

  // Checks
  AST_CARRY_BRANCH: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (accept && CE_I && INSTR_I[15:8] == 8'he2) ##1 CE_I [*4]
    |-> PC_WE_O == $past(CARRY_I, 4))
    else $error("carry branch decision wrong");
  AST_NEG_BRANCH: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (accept && CE_I && INSTR_I[15:8] == 8'he6) ##1 CE_I [*4]
    |-> PC_WE_O == $past(NEGATIVE_I, 4))
    else $error("negative branch decision wrong");
  AST_TARGET: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (accept && CE_I && INSTR_I[15:8] == 8'he2 && CARRY_I) ##1 CE_I [*4]
    |-> PC_O == $past(INSTR_PC_I, 4) + 21'h000002
               + {{12{$past(INSTR_I[7], 4)}}, $past(INSTR_I[7:0], 4), 1'b0})
    else $error("branch target wrong");
  AST_FALLTHROUGH: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (accept && CE_I && INSTR_I[15:8] == 8'he6 && !NEGATIVE_I) ##1 CE_I [*4]
    |-> DONE_O && PC_O == $past(INSTR_PC_I, 4) + 21'h000002)
    else $error("fall-through address wrong");
  AST_TAKEN_LEN: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (PC_WE_O ##1 CE_I [*4]) |-> DONE_O && !$past(DONE_O, 1))
    else $error("taken branch not two cycles");
  AST_FLUSH_IDLE: assert property (@(posedge CLK_I) disable iff (RESET_I)
    state_r == bcx_pkg::ST_FLUSH |-> !PC_WE_O && !mif.we && !mif.rd_en)
    else $error("activity in flushed cycle");
  AST_CLEAR_DATA: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (exec_q && mif.we) |-> mif.wdata == ($past(mif.rdata) & ~(8'h01 << instr_r[11:9])))
    else $error("cleared byte wrong");
  AST_BANKED_ADDR: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (accept && CE_I && INSTR_I[15:12] == 4'h9 && INSTR_I[8]) ##1 CE_I [*4]
    |-> mif.we && mif.addr == {$past(BANK_SEL_I, 4), $past(INSTR_I[7:0], 4)})
    else $error("banked address wrong");
  AST_INDEXED_ADDR: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (accept && CE_I && INSTR_I[15:12] == 4'h9 && !INSTR_I[8] && EXT_SET_EN_I
     && INSTR_I[7:0] <= 8'h5f) ##1 CE_I [*4]
    |-> mif.we && mif.addr == $past(INDEX_BASE_I, 4) + {4'h0, $past(INSTR_I[7:0], 4)})
    else $error("indexed address wrong");
  AST_RMW_ORDER: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (exec_q && mif.we && $past(CE_I) && $past(CE_I, 2)) |-> $past(mif.rd_en, 2) && DONE_O)
    else $error("write not preceded by read");
  AST_NO_STATUS: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (INSTR_VALID_I || !INSTR_READY_O) |-> !STATUS_WE_O)
    else $error("status flag written");

  COV_TAKEN: cover property (@(posedge CLK_I) disable iff (RESET_I) PC_WE_O);
  COV_NOT_TAKEN: cover property (@(posedge CLK_I) disable iff (RESET_I)
    DONE_O && exec_q && kind_r == bcx_pkg::K_BR_NEG);
  COV_CLEAR: cover property (@(posedge CLK_I) disable iff (RESET_I) exec_q && mif.we);
endmodule // bcx_exec

// ### tb/bcx_exec_tb.sv
`timescale 1ns/10ps
module bcx_exec_tb;
  logic        clk    = 1'b0;
  logic        rst    = 1'b1;
  logic        vld    = 1'b0;
  logic [15:0] instr  = 16'h0000;
  logic [20:0] ipc    = 21'h000000;
  logic        cy     = 1'b0;
  logic        ng     = 1'b0;
  logic        ext    = 1'b0;
  logic [3:0]  bptr   = 4'h0;
  logic        ce     = 1'b1;
  logic [11:0] base   = 12'h000;
  logic [11:0] daddr  = 12'h000;
  logic        dwe    = 1'b0;
  logic [7:0]  dwdata = 8'h00;
  logic        rdy;
  logic [1:0]  qph;
  logic        pcwe;
  logic [20:0] pco;
  logic        done;
  logic        stwe;
  logic [7:0]  drd;
  logic [7:0]  rv;
  int          bad_count  = 0;
  int          num_checks = 0;
  int          cyc        = 0;

  bcx_exec bcx_exec_i (
    .CLK_I(clk), .RESET_I(rst), .CE_I(ce), .INSTR_VALID_I(vld), .INSTR_I(instr),
    .INSTR_PC_I(ipc), .CARRY_I(cy), .NEGATIVE_I(ng), .EXT_SET_EN_I(ext),
    .BANK_SEL_I(bptr), .INDEX_BASE_I(base), .DBG_ADDR_I(daddr), .DBG_WE_I(dwe),
    .DBG_WDATA_I(dwdata), .INSTR_READY_O(rdy), .QPHASE_O(qph), .PC_WE_O(pcwe),
    .PC_O(pco), .DONE_O(done), .STATUS_WE_O(stwe), .DBG_RDATA_O(drd)
  );

  // Core clock, 8 ns period
  always #4 clk = ~clk;

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      $display("timeout at %0t", $time);
      results();
    end
  end

  task automatic results();
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Idle-time memory write and read
  task automatic mem_wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    daddr = a;
    dwdata = d;
    dwe = 1'b1;
    @(negedge clk);
    dwe = 1'b0;
  endtask

  task automatic mem_rd(input logic [11:0] a, output logic [7:0] d);
    @(negedge clk);
    daddr = a;
    @(negedge clk);
    d = drd;
  endtask

  // One instruction; flags flip after acceptance to prove they were latched
  task automatic run(input logic [15:0] w, input logic [20:0] a, input logic c,
                     input logic n, input int nc, input logic tk);
    logic [20:0] pe;
    pe = tk ? a + 21'h000002 + {{12{w[7]}}, w[7:0], 1'b0} : a + 21'h000002;
    @(negedge clk);
    instr = w;
    ipc = a;
    cy = c;
    ng = n;
    vld = 1'b1;
    for (int k = 1; k <= nc; k++) begin
      @(negedge clk);
      vld = 1'b0;
      cy = ~c;
      ng = ~n;
      chk({19'h0, qph}, 21'((k - 1) % 4));
      chk({20'h0, done}, {20'h0, k == nc});
      chk({20'h0, pcwe}, {20'h0, tk && k == 4});
      chk({19'h0, rdy, stwe}, 21'h000000);
    end
    chk(pco, pe);
    @(negedge clk);
    chk({20'h0, rdy}, 21'h000001);
  endtask

  // Bit clear of one location, with a decoy that must stay intact
  task automatic clr(input logic ab, input logic e, input logic [7:0] f, input logic [3:0] bs,
                     input logic [11:0] ba, input logic [11:0] ea, input logic [11:0] dc,
                     input logic [2:0] b);
    mem_wr(ea, 8'hff);
    mem_wr(dc, 8'hff);
    ext = e;
    bptr = bs;
    base = ba;
    run({4'h9, b, ab, f}, 21'h000100, 1'b1, 1'b1, 4, 1'b0);
    mem_rd(ea, rv);
    chk({13'h0, rv}, {13'h0, 8'hff & ~(8'h01 << b)});
    mem_rd(dc, rv);
    chk({13'h0, rv}, 21'h0000ff);
  endtask

  // Main sequence
  initial begin
    repeat (12) @(negedge clk);
    chk({16'h0, rdy, qph, done, pcwe}, 21'h000010);
    chk(pco, 21'h000000);
    chk({13'h0, drd}, 21'h000000);
    rst = 1'b0;
    run({8'he2, 8'h7f}, 21'h001000, 1'b1, 1'b0, 8, 1'b1);
    run({8'he2, 8'h80}, 21'h001000, 1'b0, 1'b1, 4, 1'b0);
    run({8'he6, 8'h80}, 21'h000040, 1'b0, 1'b1, 8, 1'b1);
    run({8'he6, 8'h05}, 21'h1ffffe, 1'b1, 1'b0, 4, 1'b0);
    run({8'he3, 8'h10}, 21'h000200, 1'b1, 1'b1, 4, 1'b0);
    // Clock enable low: nothing accepted, memory write ignored
    mem_wr(12'h0aa, 8'h3c);
    @(negedge clk);
    ce = 1'b0;
    instr = {8'he2, 8'h01};
    cy = 1'b1;
    vld = 1'b1;
    dwe = 1'b1;
    dwdata = 8'h00;
    repeat (3) @(negedge clk);
    chk({16'h0, rdy, qph, done, pcwe}, 21'h000010);
    vld = 1'b0;
    dwe = 1'b0;
    ce = 1'b1;
    mem_rd(12'h0aa, rv);
    chk({13'h0, rv}, 21'h00003c);
    clr(1'b1, 1'b0, 8'h45, 4'h3, 12'h200, 12'h345, 12'h045, 3'h7);
    clr(1'b0, 1'b0, 8'h10, 4'h3, 12'h200, 12'h010, 12'h310, 3'h0);
    clr(1'b0, 1'b0, 8'h80, 4'h3, 12'h200, 12'hf80, 12'h380, 3'h3);
    clr(1'b0, 1'b1, 8'h5f, 4'h3, 12'h200, 12'h25f, 12'h05f, 3'h5);
    clr(1'b0, 1'b1, 8'h60, 4'h3, 12'h200, 12'hf60, 12'h260, 3'h1);
    clr(1'b1, 1'b1, 8'h20, 4'h7, 12'h200, 12'h720, 12'h220, 3'h2);
    // Every bit position, cleared one after another in one register
    mem_wr(12'h5a5, 8'hff);
    ext = 1'b0;
    bptr = 4'h5;
    for (int b = 0; b < 8; b++) begin
      run({4'h9, 3'(b), 1'b1, 8'ha5}, 21'h000300, 1'b0, 1'b0, 4, 1'b0);
      mem_rd(12'h5a5, rv);
      chk({13'h0, rv}, {13'h0, 8'hff << (b + 1)});
    end
    results();
  end
endmodule // bcx_exec_tb
